// file: rst_seq_pkg.sv
package rst_seq_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CAUSE_FLAGS_OFS = 8'hf8;
  localparam logic [7:0] CONFIG_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;

  // Cause register field positions.
  localparam int WDOG_BIT   = 0;
  localparam int PIN_BIT    = 1;
  localparam int UV_BIT     = 2;
  localparam int POR_BIT    = 3;
  localparam int LOWSUP_BIT = 4;
  localparam int ONE_BIT    = 5;

  localparam logic [7:0] CAUSE_RESET    = 8'h28;
  localparam logic [7:0] CAUSE_RW_MASK  = 8'h1f;

  // Config register field positions.
  localparam int TOUT_LSB   = 0;
  localparam int WARM_LSB   = 2;
  localparam int SRC_LSB    = 4;
  localparam int FAST_BIT   = 6;
  localparam int WDEN_BIT   = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h40;

  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'b00,
    SRC_RC      = 2'b01,
    SRC_EXT     = 2'b10
  } clk_src_t;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_WARMUP  = 3'b011,
    ST_RUN     = 3'b010,
    ST_WDOG    = 3'b110
  } seq_state_t;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int SLOW_HZ        = 32_768;
  localparam int SLOW_DIV       = CLK_HZ / SLOW_HZ;
  localparam int BASE_MS        = 16;
  localparam int RETRY_MS       = 4;
  localparam int RETRY_COUNT    = 4;
  localparam int BASE_SLOW      = ((BASE_MS + RETRY_COUNT * RETRY_MS) * SLOW_HZ) / 1000;
  localparam int TOUT_SLOW_00   = 2 * BASE_SLOW;
  localparam int TOUT_SLOW_01   = BASE_SLOW + 512;
  localparam int TOUT_SLOW_10   = BASE_SLOW + 256;
  localparam int TOUT_SLOW_11   = BASE_SLOW + 4;
  localparam int WDOG_PULSE     = 16;
  localparam int GLITCH_NS      = 50;
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int GLITCH_CYC     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COMPAT_SAMPLE  = 6;
  localparam int COMPAT_HOLD    = 12;
  localparam int RESET_VECTOR   = 16'h0000;

endpackage

// file: rst_sync2.sv
module rst_sync2 (
  input  wire logic aclk,
  input  wire logic req_async,
  output logic      req_sync
);

  logic meta_r;

  // ---------------------------------------------------------------------------
  // Assertion is asynchronous, release passes two flops.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk or posedge req_async) begin
    if (req_async) begin
      meta_r   <= 1'b1;
      req_sync <= 1'b1;
    end else begin
      meta_r   <= 1'b0;
      req_sync <= meta_r;
    end
  end

endmodule

// file: reset_source_sequencer.sv
// Functional notes
// - While reset holds, I/O registers and ports are at defaults; fetch starts at 0000H.
// - Internal reset combines power-on, undervoltage, pin and watchdog sources.
// - Power-on reset reasserts at once; after supply rises, hold for start-up delay.
// - Power-on reset sets the power-on flag.
// - Pin still active at time-out end keeps internal reset asserted.
// - Time-out select: 64, 48, 40 or 32 ms of slow clocks.
// - Warm-up counts depend on clock source and warm-up select.
// - Reset start-up waits time-out then warm-up; STOP wake waits warm-up only.
// - Undervoltage reset asserts at once, releases after time-out once supply recovers.
// - Undervoltage reset sets the undervoltage reset flag.
// - Undervoltage detector alone emits no reset output pulse.
// - Low-supply detection never resets; it only sets its warning flag.
// - Active-low pin level resets immediately, without a clock edge; here sys_reset_n falls only after the glitch filter and one register edge.
// - Pin pulses shorter than 50 ns are ignored.
// - Pin release is synchronous; compatibility mode samples every six clocks.
// - Fast mode samples the pin every clock for release.
// - Pin reset sets the pin reset flag.
// - Watchdog expiry gives an internal reset pulse exactly 16 clocks long; here sys_reset_n stays low for 16 clocks plus the warm-up.
// - Watchdog reset sets the watchdog reset flag.
// - Flags set by hardware, cleared by software; power-on clears all but its own.
// - With watchdog enabled, access to the watchdog flag restarts the watchdog counter.
// - Bit 5 reads as one; software should clear stale undervoltage and pin flags.
// - Time-out delay counts on the 32 kHz slow reference clock.
module reset_source_sequencer
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        power_low,
  input  wire logic        undervoltage_reset,
  input  wire logic        low_supply_detect,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_expire,
  input  wire logic        stop_wake,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sys_reset_n,
  output logic             cpu_run,
  output logic [15:0]      fetch_addr,
  output logic             watchdog_restart,
  output logic             watchdog_enable
);

  import rst_seq_pkg::*;

  // ---------------------------------------------------------------------------
  // Source synchronisers
  // ---------------------------------------------------------------------------
  logic por_sync;
  logic uv_sync;
  logic pin_sync;

  // The aresetn input models the core power-on detector together with power_low.
  rst_sync2 u_por_sync (.aclk(aclk), .req_async(power_low), .req_sync(por_sync));
  rst_sync2 u_uv_sync  (.aclk(aclk), .req_async(undervoltage_reset), .req_sync(uv_sync));
  rst_sync2 u_pin_sync (.aclk(aclk), .req_async(~external_reset_pin_n), .req_sync(pin_sync));

  // ---------------------------------------------------------------------------
  // Pin glitch filter and release sampling
  // ---------------------------------------------------------------------------
  logic [3:0] glitch_cnt_r;
  logic       pin_hit_r;
  logic [2:0] sample_cnt_r;
  logic [3:0] inactive_cnt_r;
  logic       pin_hold_r;
  logic [7:0] config_r;
  logic       fast_mode;

  assign fast_mode = config_r[FAST_BIT];

  // The synchroniser stretches each pulse by two edges, so the filter waits one edge past its width.
  always_ff @(posedge aclk) begin
    if (!aresetn || !pin_sync) begin
      glitch_cnt_r <= 4'h0;
      pin_hit_r    <= 1'b0;
    end else if (glitch_cnt_r < 4'(GLITCH_CYC + 1)) begin
      glitch_cnt_r <= glitch_cnt_r + 4'h1;
    end else begin
      pin_hit_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_cnt_r <= 3'h0;
    end else if (sample_cnt_r == 3'(COMPAT_SAMPLE - 1)) begin
      sample_cnt_r <= 3'h0;
    end else begin
      sample_cnt_r <= sample_cnt_r + 3'h1;
    end
  end

  // Pin reset stays held until the release sampling sees it inactive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_hold_r     <= 1'b0;
      inactive_cnt_r <= 4'h0;
    end else if (pin_hit_r) begin
      pin_hold_r     <= 1'b1;
      inactive_cnt_r <= 4'h0;
    end else if (pin_hold_r) begin
      if (fast_mode) begin
        if (!pin_sync) begin
          pin_hold_r <= 1'b0;
        end
      end else if (sample_cnt_r == 3'h0) begin
        if (pin_sync) begin
          inactive_cnt_r <= 4'h0;
        end else if (inactive_cnt_r >= 4'(COMPAT_HOLD - COMPAT_SAMPLE)) begin
          pin_hold_r     <= 1'b0;
          inactive_cnt_r <= 4'h0;
        end else begin
          inactive_cnt_r <= inactive_cnt_r + 4'(COMPAT_SAMPLE);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Slow reference enable and watchdog pulse
  // ---------------------------------------------------------------------------
  logic [10:0] slow_div_r;
  logic        slow_tick;
  logic [4:0]  wdog_cnt_r;
  logic        wdog_active;

  assign slow_tick   = (slow_div_r == 11'(SLOW_DIV - 1));
  assign wdog_active = (wdog_cnt_r != 5'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn || slow_tick) begin
      slow_div_r <= 11'h000;
    end else begin
      slow_div_r <= slow_div_r + 11'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_cnt_r <= 5'h00;
    end else if (watchdog_expire && config_r[WDEN_BIT] && !wdog_active) begin
      wdog_cnt_r <= 5'(WDOG_PULSE);
    end else if (wdog_active) begin
      wdog_cnt_r <= wdog_cnt_r - 5'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------------------
  seq_state_t  state_r;
  logic [11:0] tout_cnt_r;
  logic [11:0] warm_cnt_r;
  logic [11:0] tout_len;
  logic [11:0] warm_len;
  logic        long_hold;

  // Undervoltage joins the long hold so its release also waits the time-out.
  assign long_hold = por_sync | uv_sync;

  assign tout_len = (config_r[TOUT_LSB +: 2] == 2'b00) ? 12'(TOUT_SLOW_00) :
                    (config_r[TOUT_LSB +: 2] == 2'b01) ? 12'(TOUT_SLOW_01) :
                    (config_r[TOUT_LSB +: 2] == 2'b10) ? 12'(TOUT_SLOW_10) : 12'(TOUT_SLOW_11);

  // Rows are crystal, internal RC and external clock; the spare source code repeats the external row.
  localparam logic [11:0] WARM_TAB [16] = '{12'h800, 12'h400, 12'h100, 12'h040,
                                            12'h400, 12'h100, 12'h040, 12'h008,
                                            12'h040, 12'h008, 12'h000, 12'h000,
                                            12'h040, 12'h008, 12'h000, 12'h000};

  assign warm_len = WARM_TAB[{config_r[SRC_LSB +: 2], config_r[WARM_LSB +: 2]}];

  always_ff @(posedge aclk) begin
    if (!aresetn || long_hold) begin
      state_r    <= ST_HOLD;
      tout_cnt_r <= 12'h000;
      warm_cnt_r <= 12'h000;
    end else begin
      case (state_r)
        ST_HOLD: begin
          tout_cnt_r <= 12'h000;
          state_r    <= ST_TIMEOUT;
        end
        ST_TIMEOUT: begin
          if (tout_cnt_r >= tout_len) begin
            if (!pin_hold_r) begin
              warm_cnt_r <= 12'h000;
              state_r    <= ST_WARMUP;
            end
          end else if (slow_tick) begin
            tout_cnt_r <= tout_cnt_r + 12'h001;
          end
        end
        ST_WARMUP: begin
          if (pin_hold_r) begin
            warm_cnt_r <= 12'h000;
          end else if (warm_cnt_r >= warm_len) begin
            state_r <= ST_RUN;
          end else begin
            warm_cnt_r <= warm_cnt_r + 12'h001;
          end
        end
        ST_RUN: begin
          if (pin_hold_r || wdog_active) begin
            state_r <= ST_WDOG;
          end else if (stop_wake) begin
            warm_cnt_r <= 12'h000;
            state_r    <= ST_WARMUP;
          end
        end
        default: begin
          // Short resets skip the time-out and only rewarm.
          if (!pin_hold_r && !wdog_active) begin
            warm_cnt_r <= 12'h000;
            state_r    <= ST_WARMUP;
          end
        end
      endcase
    end
  end

  // Pin and watchdog assert reset one edge after the filtered pin_hit_r or the wdog_active count is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_n <= 1'b0;
      cpu_run     <= 1'b0;
      fetch_addr  <= 16'(RESET_VECTOR);
    end else begin
      sys_reset_n <= (state_r == ST_RUN) && !long_hold && !pin_hit_r && !wdog_active;
      cpu_run     <= (state_r == ST_RUN);
      if (state_r != ST_RUN) begin
        fetch_addr <= 16'(RESET_VECTOR);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] cause_r;
  logic       wr_go;
  logic       rd_go;
  logic       wr_cause;
  logic       rd_cause;
  logic       pin_hit_d_r;
  logic       uv_d_r;

  assign wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awready;
  assign rd_go    = s_axi_arvalid && s_axi_arready;
  assign wr_cause = wr_go && (s_axi_awaddr[7:0] == CAUSE_FLAGS_OFS) && s_axi_wstrb[0];
  assign rd_cause = rd_go && (s_axi_araddr[7:0] == CAUSE_FLAGS_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_hit_d_r <= 1'b0;
      uv_d_r      <= 1'b0;
    end else begin
      pin_hit_d_r <= pin_hit_r;
      uv_d_r      <= uv_sync;
    end
  end

  // Writing one to a flag clears it; a hardware set in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= CAUSE_RESET;
    end else if (por_sync) begin
      cause_r <= CAUSE_RESET;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_cause && s_axi_wdata[i]) begin
          cause_r[i] <= 1'b0;
        end
      end
      if (low_supply_detect) cause_r[LOWSUP_BIT] <= 1'b1;
      if (uv_sync && !uv_d_r) cause_r[UV_BIT] <= 1'b1;
      if (pin_hit_r && !pin_hit_d_r) cause_r[PIN_BIT] <= 1'b1;
      if (watchdog_expire && config_r[WDEN_BIT] && !wdog_active) cause_r[WDOG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= CONFIG_RESET;
    end else if (wr_go && (s_axi_awaddr[7:0] == CONFIG_OFS) && s_axi_wstrb[0]) begin
      config_r <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_restart <= 1'b0;
      watchdog_enable  <= 1'b0;
    end else begin
      watchdog_restart <= config_r[WDEN_BIT] && (wr_cause || rd_cause);
      watchdog_enable  <= config_r[WDEN_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr[7:0] == CAUSE_FLAGS_OFS || s_axi_awaddr[7:0] == CONFIG_OFS) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (s_axi_araddr[7:0] == CAUSE_FLAGS_OFS) begin
          s_axi_rdata <= {24'h000000, cause_r};
        end else if (s_axi_araddr[7:0] == CONFIG_OFS) begin
          s_axi_rdata <= {24'h000000, config_r};
        end else if (s_axi_araddr[7:0] == STATUS_OFS) begin
          s_axi_rdata <= {26'h0, pin_hold_r, long_hold, wdog_active, state_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: rst_seq_props.sv
module rst_seq_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        power_low,
  input wire logic        undervoltage_reset,
  input wire logic        external_reset_pin_n,
  input wire logic        sys_reset_n,
  input wire logic        cpu_run,
  input wire logic [15:0] fetch_addr,
  input wire logic        watchdog_restart,
  input wire logic        watchdog_enable,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The windows allow for the two-flop synchronisers and the pin glitch filter.
  chk_por_reset_now: assert property (power_low [*5] |-> !sys_reset_n)
    else $error("power loss did not hold internal reset");
  chk_uv_reset_now: assert property (undervoltage_reset [*5] |-> !sys_reset_n)
    else $error("undervoltage did not hold internal reset");
  chk_pin_reset_now: assert property (!external_reset_pin_n [*6] |-> !sys_reset_n)
    else $error("pin low did not hold internal reset");
  chk_fetch_vector: assert property (!cpu_run |-> fetch_addr == 16'h0000)
    else $error("fetch address not at reset vector");
  chk_restart_pulse: assert property (watchdog_restart |-> watchdog_enable ##1 !watchdog_restart)
    else $error("watchdog restart without enable or too long");
  chk_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_refused: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
endmodule

bind reset_source_sequencer rst_seq_props props (
  .aclk, .aresetn, .power_low, .undervoltage_reset, .external_reset_pin_n,
  .sys_reset_n, .cpu_run, .fetch_addr, .watchdog_restart, .watchdog_enable,
  .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp,
  .s_axi_rdata
);

// file: board_model.sv
module board_model
  import rst_seq_pkg::*;
(
  input  wire logic aclk,
  input  wire logic por_req,
  input  wire logic uv_req,
  input  wire logic lowsup_req,
  input  wire logic pin_req,
  input  wire logic glitch_req,
  input  wire logic wdog_req,
  output logic      power_low,
  output logic      undervoltage_reset,
  output logic      low_supply_detect,
  output logic      external_reset_pin_n,
  output logic      watchdog_expire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idle_r;

  initial begin
    power_low = 1'b0;
    undervoltage_reset = 1'b0;
    low_supply_detect = 1'b0;
    external_reset_pin_n = 1'b1;
    watchdog_expire = 1'b0;
    idle_r = 4'(COMPAT_HOLD);
  end

  always @(posedge aclk) begin
    power_low <= por_req;
    undervoltage_reset <= uv_req;
    low_supply_detect <= lowsup_req;
    watchdog_expire <= wdog_req;
  end

  // A press that comes before the pin has rested high long enough is delayed.
  always @(posedge aclk) begin
    if ((pin_req || glitch_req) && (!external_reset_pin_n || idle_r >= 4'(COMPAT_HOLD))) begin
      external_reset_pin_n <= 1'b0;
      idle_r <= 4'd0;
    end else begin
      external_reset_pin_n <= 1'b1;
      if (idle_r < 4'(COMPAT_HOLD)) idle_r <= idle_r + 4'd1;
    end
  end
endmodule

// file: test_reset_source_sequencer.sv
module test_reset_source_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_seq_pkg::*;

  localparam int LIMIT = 20000;
  localparam logic [31:0] CAUSE_A = {24'h0, CAUSE_FLAGS_OFS};
  localparam logic [31:0] CFG_A = {24'h0, CONFIG_OFS};

  logic        aclk, aresetn, stop_wake, sys_reset_n, cpu_run;
  logic        power_low, undervoltage_reset, low_supply_detect;
  logic        external_reset_pin_n, watchdog_expire;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, watchdog_restart, watchdog_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] fetch_addr;
  logic        por_req, uv_req, lowsup_req, pin_req, glitch_req, wdog_req;
  logic        restart_seen;
  logic [31:0] seed, rdat;
  logic [7:0]  exp_flags;
  int          err_total, cmp_count, cycles;

  reset_source_sequencer uut (
    .aclk, .aresetn, .power_low, .undervoltage_reset, .low_supply_detect,
    .external_reset_pin_n, .watchdog_expire, .stop_wake,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sys_reset_n, .cpu_run, .fetch_addr,
    .watchdog_restart, .watchdog_enable
  );

  board_model board (
    .aclk, .por_req, .uv_req, .lowsup_req, .pin_req, .glitch_req, .wdog_req,
    .power_low, .undervoltage_reset, .low_supply_detect, .external_reset_pin_n,
    .watchdog_expire
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (watchdog_restart === 1'b1) restart_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      $display("CHECK FAILED at %0t: run too long", $time);
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Source order is {power, undervoltage, low supply, pin, watchdog}.
  function automatic logic [7:0] set_bits(input logic [4:0] w);
    return {3'b000, w[2], 1'b0, w[3], w[1], w[0]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic check_flags(input string what);
    rd(CAUSE_A, rdat, rsp);
    check({30'h0, rsp}, 32'h0, what);
    check(rdat, {24'h0, exp_flags}, what);
  endtask

  // Twenty idle cycles cover the synchronisers and the pin's rest time.
  task automatic raise(input logic [4:0] w, input int n);
    @(posedge aclk);
    {por_req, uv_req, lowsup_req, pin_req, wdog_req} <= w;
    repeat (n) @(posedge aclk);
    {por_req, uv_req, lowsup_req, pin_req, wdog_req} <= 5'b0;
    repeat (20) @(posedge aclk);
  endtask

  initial begin
    {por_req, uv_req, lowsup_req, pin_req, glitch_req, wdog_req} = 6'b0;
    {aresetn, stop_wake, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b0;
    {s_axi_arvalid, s_axi_rready, restart_seen} = 3'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    seed = 32'd30543;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    exp_flags = CAUSE_RESET;
    check_flags("cause after reset");
    rd(CFG_A, rdat, rsp);
    check(rdat, {24'h0, CONFIG_RESET}, "config after reset");
    check({31'h0, restart_seen}, 32'h0, "restart while disabled");
    check({15'h0, cpu_run, fetch_addr}, 32'h0, "cpu held at vector");
    check({31'h0, sys_reset_n}, 32'h0, "start-up delay running");
    wr(CAUSE_A, 32'h0000_001f, rsp);
    exp_flags = 8'h20;
    check_flags("software clear");
    $display("reset values done");
    @(posedge aclk);
    glitch_req <= 1'b1;
    @(posedge aclk);
    glitch_req <= 1'b0;
    repeat (20) @(posedge aclk);
    check_flags("pin glitch");
    $display("glitch done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      raise({1'b0, seed[3:0]}, 4 + int'(seed[6:4]));
      // The watchdog is still disabled, so its expiry must leave no flag.
      exp_flags = exp_flags | set_bits({1'b0, seed[3:1], 1'b0});
      check_flags("flags after sources");
      seed = xs(seed);
      wr(CAUSE_A, seed, rsp);
      exp_flags = exp_flags & ~(seed[7:0] & CAUSE_RW_MASK);
      check_flags("random clear");
    end
    raise(5'b01111, 8);
    exp_flags = exp_flags | set_bits(5'b01110);
    check_flags("all sources");
    $display("random sources done");
    rd(32'h0000_0010, rdat, rsp);
    check({30'h0, rsp}, 32'h2, "unmapped read");
    check(rdat, 32'h0, "unmapped read data");
    wr(32'h0000_0010, 32'h0000_00ff, rsp);
    check({30'h0, rsp}, 32'h2, "unmapped write");
    $display("unmapped done");
    wr(CFG_A, 32'h0000_00c0, rsp);
    // The enable output is registered one edge after the configuration write lands.
    @(posedge aclk);
    check({31'h0, watchdog_enable}, 32'h1, "watchdog enabled");
    rd(CAUSE_A, rdat, rsp);
    repeat (2) @(posedge aclk);
    check({31'h0, restart_seen}, 32'h1, "restart on access");
    raise(5'b00001, 4);
    exp_flags = exp_flags | 8'h01;
    check_flags("watchdog flag");
    $display("watchdog restart done");
    raise(5'b10000, 8);
    exp_flags = CAUSE_RESET;
    check_flags("power-on flags");
    $display("power-on done");
    give_verdict();
  end
endmodule
